// ---- design/csel_pkg.sv ----
// constants for the chip-select pin and timing block
package csel_pkg;
  localparam int N_SEL = 12;
  localparam int BOOT_IDX = 11;
  localparam int SLOW_PERIPHERAL_CLOCK_IDX = 10;
  localparam int FIRST_PORTC = 3;
  localparam int LAST_PORTC = 9;
  // pin assignment codes
  localparam logic [1:0] PA_DISCRETE = 2'h0;
  localparam logic [1:0] PA_ALT = 2'h1;
  localparam logic [1:0] PA_CS8 = 2'h2;
  localparam logic [1:0] PA_CS16 = 2'h3;
  // byte field
  localparam logic [1:0] BYTE_OFF = 2'h0;
  localparam logic [1:0] BYTE_BOOT_RST = 2'h3;
  // read/write field
  localparam logic [1:0] RW_READ = 2'h1;
  localparam logic [1:0] RW_WRITE = 2'h2;
  // space field
  localparam logic [1:0] SP_CPU = 2'h0;
  localparam logic [1:0] SP_USER = 2'h1;
  localparam logic [1:0] SP_SUPV = 2'h2;
  localparam logic [1:0] SP_BOTH = 2'h3;
  localparam logic [2:0] FC_CPU = 3'h7;
  localparam logic [2:0] IPL_ANY = 3'h0;
  // wait field
  localparam logic [3:0] WAIT_FAST = 4'he;
  localparam logic [3:0] WAIT_EXT = 4'hf;
  localparam logic [3:0] WAIT_ZERO = 4'h0;
  localparam logic [3:0] WAIT_ONE = 4'h1;
  localparam int BASE_W = 13;
endpackage : csel_pkg

// ---- design/csel_pin_timing.sv ----
// chip-select pin function and access timing logic
// Overview of operation
// RL1: twelve two-bit pin function fields
// RL2: codes: discrete, alternate, 8-bit, 16-bit select
// RL3: zero code unused on pins without discrete
// RL4: discrete drives port C; top pin slow clock
// RL5: matching continues under discrete or alternate
// RL6: reset: selects assigned, general disabled, boot on
// RL7: disabled select never asserts, pin high
// RL8: alternate enabled if data pins low
// RL9: compare address, space, direction, byte, level
// RL10: active low; strobe or slow clock timing
// RL11: internal access wins, no select
// RL12: one clock per wait state from S3
// RL13: fast termination gives two-clock access
// RL14: first acknowledge ends the cycle
// RL15: external option waits without limit
// RL16: overlapping selects share one wait count
// RL17: slow-clock match flags pending, waits grant
// RL18: 8-bit multi-transfers run back to back
// RL19: bus monitor longer than two slow cycles
// RL20: wait field ignored in slow-clock mode
// RL21: strobe cycle ends on acknowledge or autovector
// RL22: wait codes 0-13, 14 fast, 15 external
// RL23: strobe select: address or data strobe
// RL24: 8-bit raises low ack, 16-bit high ack
`timescale 1ns/1ns
`default_nettype none
module csel_pin_timing
  import csel_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // configuration, per select, packed by index
  input wire logic [2*N_SEL-1:0] PIN_FUNC_WR_I,
  input wire logic PIN_FUNC_WE_I,
  input wire logic [N_SEL-1:0] OPT_WE_I,
  input wire logic [2*N_SEL-1:0] OPT_BYTE_I,
  input wire logic [2*N_SEL-1:0] OPT_RW_I,
  input wire logic [2*N_SEL-1:0] OPT_SPACE_I,
  input wire logic [3*N_SEL-1:0] OPT_IPL_I,
  input wire logic [4*N_SEL-1:0] OPT_WAIT_I,
  input wire logic [N_SEL-1:0] OPT_MODE_I,
  input wire logic [N_SEL-1:0] OPT_STROBE_SELECT_I,
  input wire logic [N_SEL-1:0] OPT_AUTOVECTOR_REQUEST_I,
  input wire logic [BASE_W*N_SEL-1:0] OPT_BASE_I,
  input wire logic [BASE_W*N_SEL-1:0] OPT_MASK_I,
  input wire logic [6:0] PORTC_DATA_I,
  // data bus straps sampled at reset release, one per pin
  input wire logic [N_SEL-1:0] STRAP_LOW_I,
  // internal cpu bus
  input wire logic [23:0] ADDR_I,
  input wire logic [2:0] FC_I,
  input wire logic RD_I,
  input wire logic [1:0] SIZE_I,
  input wire logic IACK_I,
  input wire logic INTERNAL_HIT_I,
  input wire logic AS_I,
  input wire logic DS_I,
  input wire logic EXT_ACK_I,
  input wire logic SLOW_CLK_I,
  input wire logic EBU_GRANT_I,
  // outputs
  output var logic [N_SEL-1:0] SEL_N_O,
  output var logic [N_SEL-1:0] PIN_ALT_O,
  output var logic [N_SEL-1:0] PIN_DISC_O,
  output var logic [N_SEL-1:0] PIN_DISC_VAL_O,
  output var logic ACK_LO_O,
  output var logic ACK_HI_O,
  output var logic AUTOVECTOR_REQUEST_O,
  output var logic SLOW_PEND_O,
  output var logic CYCLE_END_O,
  output var logic [1:0] PIN_FUNC_O
);

  // one-hot sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } bus_e;

  // all state in one record; d is its next value
  typedef struct packed {
    logic [2*N_SEL-1:0] func;
    logic [2*N_SEL-1:0] byte_f;
    logic [N_SEL-1:0] sel_n;
    logic [N_SEL-1:0] alt;
    logic [N_SEL-1:0] disc;
    logic [N_SEL-1:0] disc_val;
    logic ack_lo;
    logic ack_hi;
    logic autovector_request;
    logic pend;
    logic cyc_end;
    logic [3:0] wcnt;
    logic wsize8;
    logic wavec;
    logic [1:0] strap_seen;
    logic [N_SEL-1:0] strap_s1;
    logic [N_SEL-1:0] strap_s2;
    logic [1:0] slow_s;
    logic slow_prev;
    logic [1:0] grant_s;
    bus_e st;
  } state_s;

  state_s q, d;

  // per-select match terms, one entry per select
  logic [N_SEL-1:0] match;
  logic [N_SEL-1:0] en;

  // option levels except the byte field are read live: change them only between cycles
  genvar g;
  generate
    for (g = 0; g < N_SEL; g++) begin : g_sel
      logic [1:0] bf;
      logic [1:0] rw;
      logic [1:0] sp;
      logic [2:0] interrupt_level_match;
      logic [BASE_W-1:0] base;
      logic [BASE_W-1:0] mask;
      logic addr_ok;
      logic sp_ok;
      logic rw_ok;
      logic byte_ok;
      logic ipl_ok;
      logic is16;
      assign bf = q.byte_f[2*g +: 2];
      assign rw = OPT_RW_I[2*g +: 2];
      assign sp = OPT_SPACE_I[2*g +: 2];
      assign interrupt_level_match = OPT_IPL_I[3*g +: 3];
      assign base = OPT_BASE_I[BASE_W*g +: BASE_W];
      assign mask = OPT_MASK_I[BASE_W*g +: BASE_W];
      assign is16 = q.func[2*g +: 2] == PA_CS16;
      // upper address compare, mask set where block size ignores bits
      assign addr_ok = ((ADDR_I[23:11] ^ base) & ~mask) == '0; // RL9
      always_comb begin
        unique case (sp)
          SP_CPU: sp_ok = FC_I == FC_CPU;
          SP_USER: sp_ok = FC_I[2] == 1'b0 && FC_I != 3'h0;
          SP_SUPV: sp_ok = FC_I[2] == 1'b1 && FC_I != FC_CPU;
          SP_BOTH: sp_ok = FC_I != FC_CPU;
        endcase
      end
      assign rw_ok = RD_I ? rw[0] : rw[1]; // RL9
      // word access takes both lanes, byte access one lane by addr0
      assign byte_ok = !is16 ? 1'b1 :
        (SIZE_I == 2'h1) ? (ADDR_I[0] ? bf[1] : bf[0]) : bf == 2'h3; // RL9
      assign ipl_ok = !IACK_I || interrupt_level_match == IPL_ANY || interrupt_level_match == ADDR_I[3:1]; // RL9
      assign en[g] = bf != BYTE_OFF; // RL7
      // internal hit suppresses every select
      assign match[g] = en[g] && !INTERNAL_HIT_I && addr_ok && sp_ok &&
        rw_ok && byte_ok && ipl_ok; // RL11
    end
  endgenerate

  // wait count and size of lowest matching strobe-timed select
  logic [3:0] wsel;
  logic w8;
  logic wav;
  logic any_async;
  always_comb begin
    wsel = WAIT_EXT;
    w8 = 1'b0;
    wav = 1'b0;
    any_async = 1'b0;
    // shared counter: conflicting settings resolve to lowest index
    for (int i = N_SEL - 1; i >= 0; i--) begin
      if (match[i] && !OPT_MODE_I[i]) begin // RL20
        wsel = OPT_WAIT_I[4*i +: 4]; // RL16
        w8 = q.func[2*i +: 2] == PA_CS8;
        wav = OPT_AUTOVECTOR_REQUEST_I[i] && IACK_I;
        any_async = 1'b1;
      end
    end
  end

  // rise taken from the second stage and its delayed copy only;
  // the first stage may still be settling from the async pin
  logic slow_rise;
  assign slow_rise = q.slow_s[1] && !q.slow_prev;

  always_comb begin
    d = q;
    d.ack_lo = 1'b0;
    d.ack_hi = 1'b0;
    d.autovector_request = 1'b0;
    d.cyc_end = 1'b0;
    d.slow_s = {q.slow_s[0], SLOW_CLK_I};
    d.slow_prev = q.slow_s[1];
    d.grant_s = {q.grant_s[0], EBU_GRANT_I};
    d.strap_s1 = STRAP_LOW_I;
    d.strap_s2 = q.strap_s1;
    // straps taken once, on the third clock after reset release
    // a later field write still overrides a strapped function
    if (q.strap_seen != 2'h3) begin
      d.strap_seen = q.strap_seen + 2'h1;
      if (q.strap_seen == 2'h2) begin
        for (int i = 0; i < N_SEL; i++) begin
          if (q.strap_s2[i] && i != BOOT_IDX) begin
            d.func[2*i +: 2] = PA_ALT; // RL8
          end
        end
      end
    end
    if (PIN_FUNC_WE_I) begin
      d.func = PIN_FUNC_WR_I; // RL1
      // pins without discrete function never take code zero
      for (int i = 0; i < FIRST_PORTC; i++) begin
        if (PIN_FUNC_WR_I[2*i +: 2] == PA_DISCRETE) begin
          d.func[2*i +: 2] = q.func[2*i +: 2]; // RL3
        end
      end
      if (PIN_FUNC_WR_I[2*BOOT_IDX +: 2] == PA_DISCRETE) begin
        d.func[2*BOOT_IDX +: 2] = q.func[2*BOOT_IDX +: 2]; // RL3
      end
    end
    for (int i = 0; i < N_SEL; i++) begin
      if (OPT_WE_I[i]) begin
        d.byte_f[2*i +: 2] = OPT_BYTE_I[2*i +: 2];
      end
    end
    // pin function decode
    for (int i = 0; i < N_SEL; i++) begin
      d.alt[i] = q.func[2*i +: 2] == PA_ALT; // RL2
      d.disc[i] = q.func[2*i +: 2] == PA_DISCRETE;
      d.disc_val[i] = 1'b1;
      if (i >= FIRST_PORTC && i <= LAST_PORTC) begin
        d.disc_val[i] = PORTC_DATA_I[i - FIRST_PORTC]; // RL4
      end else if (i == SLOW_PERIPHERAL_CLOCK_IDX) begin
        d.disc_val[i] = q.slow_s[1]; // RL4
      end
    end
    // select pins, only on cs-assigned pins, never when disabled
    for (int i = 0; i < N_SEL; i++) begin
      logic strobe;
      logic as_cs;
      strobe = OPT_STROBE_SELECT_I[i] ? DS_I : AS_I; // RL23
      as_cs = q.func[2*i +: 2] == PA_CS8 || q.func[2*i +: 2] == PA_CS16;
      d.sel_n[i] = 1'b1; // RL7
      if (match[i] && as_cs) begin
        if (!OPT_MODE_I[i]) begin
          d.sel_n[i] = !strobe; // RL10
        end else begin
          d.sel_n[i] = !(q.grant_s[1] && q.pend == 1'b0); // RL17
        end
      end
    end
    // slow-clock cycle pending until the bus unit grants
    // rebuilt from the live match on every clock; a slow-clock rise also holds a set flag
    d.pend = 1'b0;
    for (int i = 0; i < N_SEL; i++) begin
      if (match[i] && OPT_MODE_I[i] && AS_I && !q.grant_s[1]) begin
        d.pend = 1'b1; // RL17
      end
    end
    // back-to-back 8-bit transfers: no gap state between grants
    if (slow_rise && q.pend) begin
      d.pend = 1'b1; // RL18
    end
    // internal acknowledge sequencer, strobe-timed only
    // one shared counter: only one internal cycle can run at a time
    unique case (q.st)
      ST_IDLE: begin
        if (AS_I && any_async && wsel != WAIT_EXT) begin // RL15
          d.wsize8 = w8;
          d.wavec = wav;
          if (wsel == WAIT_FAST) begin
            d.st = ST_DONE; // RL13
            d.wcnt = WAIT_ZERO;
          end else begin
            // full count loaded, so zero waits still costs one clock
            // more than fast termination
            d.st = ST_WAIT; // RL12
            d.wcnt = wsel; // RL22
          end
        end
        // external acknowledge also ends cycles with no internal count
        if (AS_I && EXT_ACK_I) begin
          d.st = ST_IDLE; // RL14
          d.cyc_end = 1'b1;
        end
      end
      ST_WAIT: begin
        if (EXT_ACK_I || !AS_I) begin
          d.st = ST_IDLE; // RL14
          d.cyc_end = EXT_ACK_I;
        end else if (q.wcnt == WAIT_ZERO) begin
          d.st = ST_DONE;
        end else begin
          d.wcnt = q.wcnt - WAIT_ONE; // RL12
        end
      end
      ST_DONE: begin
        d.st = ST_IDLE;
        d.cyc_end = 1'b1; // RL21
        if (!EXT_ACK_I) begin
          if (q.wavec) begin
            d.autovector_request = 1'b1; // RL21
          end else begin
            d.ack_lo = q.wsize8; // RL24
            d.ack_hi = !q.wsize8; // RL24
          end
        end
      end
    endcase
    // internal matching keeps acknowledging on discrete or alt pins
    // because match checks pin function only for the 16-bit byte lanes
    // reset last, so it overrides every update above
    if (RST_I) begin
      d = '0;
      d.st = ST_IDLE;
      d.sel_n = '1;
      d.disc_val = '1;
      for (int i = 0; i < N_SEL; i++) begin
        d.func[2*i +: 2] = PA_CS16; // RL6
      end
      d.byte_f[2*BOOT_IDX +: 2] = BYTE_BOOT_RST; // RL6
    end
  end

  // single state register; matching needs no extra term (RL5 path)
  always_ff @(posedge CLK_SYS_I) begin
    q <= d; // RL5
  end

  // every output comes straight from the state register
  assign SEL_N_O = q.sel_n;
  assign PIN_ALT_O = q.alt;
  assign PIN_DISC_O = q.disc;
  assign PIN_DISC_VAL_O = q.disc_val;
  assign ACK_LO_O = q.ack_lo;
  assign ACK_HI_O = q.ack_hi;
  assign AUTOVECTOR_REQUEST_O = q.autovector_request;
  assign SLOW_PEND_O = q.pend;
  assign CYCLE_END_O = q.cyc_end;
  assign PIN_FUNC_O = q.func[2*BOOT_IDX +: 2];

endmodule : csel_pin_timing
`default_nettype wire

// ---- bench/csel_checker.sv ----
// port assertions for the chip-select pin and timing block
`timescale 1ns/1ns
`default_nettype none
module csel_checker (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic AS_I,
  input wire logic INTERNAL_HIT_I,
  input wire logic [11:0] OPT_MODE_I,
  input wire logic [6:0] PORTC_DATA_I,
  input wire logic [11:0] SEL_N_O,
  input wire logic [11:0] PIN_DISC_O,
  input wire logic [11:0] PIN_DISC_VAL_O,
  input wire logic ACK_LO_O,
  input wire logic ACK_HI_O,
  input wire logic AUTOVECTOR_REQUEST_O,
  input wire logic CYCLE_END_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  property p_rst; $fell(RST_I) |-> (&SEL_N_O) && !CYCLE_END_O; endproperty
  a_rst: assert property (p_rst) else $error("select active at reset");
  property p_int; INTERNAL_HIT_I && $past(INTERNAL_HIT_I) && AS_I |=> &SEL_N_O;
  endproperty
  a_int: assert property (p_int) else $error("select on internal hit");
  property p_end; ACK_LO_O || ACK_HI_O || AUTOVECTOR_REQUEST_O |-> CYCLE_END_O; endproperty
  a_end: assert property (p_end) else $error("ack without cycle end");
  property p_lane; ACK_HI_O |-> !ACK_LO_O; endproperty
  a_lane: assert property (p_lane) else $error("both ack lanes");
  property p_one; CYCLE_END_O |=> !CYCLE_END_O; endproperty
  a_one: assert property (p_one) else $error("cycle end too long");
  // strobe mode: select trails the strobe by one cycle only
  property p_idle; !AS_I && !$past(AS_I) && OPT_MODE_I == 12'h000 |-> &SEL_N_O;
  endproperty
  a_idle: assert property (p_idle) else $error("select without strobe");
  property p_nodisc; PIN_DISC_O[11] == 1'b0 && PIN_DISC_O[2:0] == 3'h0; endproperty
  a_nodisc: assert property (p_nodisc) else $error("bad discrete pin");
  property p_portc; PIN_DISC_O[3] && $past(PIN_DISC_O[3])
    |-> PIN_DISC_VAL_O[3] == $past(PORTC_DATA_I[0]); endproperty
  a_portc: assert property (p_portc) else $error("discrete level wrong");
endmodule : csel_checker
bind csel_pin_timing csel_checker i_csel_checker (.CLK_SYS_I(CLK_SYS_I),
  .RST_I(RST_I), .AS_I(AS_I), .INTERNAL_HIT_I(INTERNAL_HIT_I),
  .OPT_MODE_I(OPT_MODE_I), .PORTC_DATA_I(PORTC_DATA_I), .SEL_N_O(SEL_N_O),
  .PIN_DISC_O(PIN_DISC_O), .PIN_DISC_VAL_O(PIN_DISC_VAL_O),
  .ACK_LO_O(ACK_LO_O), .ACK_HI_O(ACK_HI_O), .AUTOVECTOR_REQUEST_O(AUTOVECTOR_REQUEST_O),
  .CYCLE_END_O(CYCLE_END_O));
`default_nettype wire

// ---- bench/ext_periph.sv ----
// external peripheral that answers with its own acknowledge
`timescale 1ns/1ns
`default_nettype none
module ext_periph (
  input wire logic clk_i,
  input wire logic sel_n_i,
  input wire logic en_i,
  input wire logic [7:0] dly_i,
  output logic ack_o
);
  logic [7:0] cnt = 8'h00;
  initial ack_o = 1'b0;
  // ack held until the select lets go, as a slow device would
  always @(posedge clk_i) begin
    cnt <= sel_n_i ? 8'h00 : cnt + 8'h01;
    ack_o <= en_i && !sel_n_i && cnt >= dly_i;
  end
endmodule : ext_periph
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the chip-select pin and timing block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import csel_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [23:0] pf = 24'hffffff, byt = 24'hffffff, sp = 24'hffffff;
  logic [23:0] rw = 24'hffffff;
  logic [11:0] owe = 12'h000, md = 12'h000, strobe_select = 12'h000, av = 12'h000;
  logic [11:0] strap = 12'h000;
  logic [35:0] interrupt_level_match = 36'h0;
  // general selects on the boot range stay disabled: one count only
  logic [47:0] wt = {4'h2, 44'h0};
  logic [155:0] base = 156'h0;
  logic [155:0] mask = {13'h00ff, 143'h0};
  logic [6:0] pc = 7'h55;
  logic [23:0] addr = 24'h0;
  logic [2:0] fc = 3'h5;
  logic [1:0] siz = 2'h1;
  logic pf_we = 1'b0, rd = 1'b1, as = 1'b0, hit = 1'b0, iack = 1'b0;
  logic slow = 1'b0, grant = 1'b0, xen = 1'b0, xack;
  logic [7:0] xdly = 8'h02;
  logic [11:0] sel_n, alt, disc, dval, seen;
  logic lo, hi, avo, pend, ce, got_lo, got_hi, got_av;
  logic [1:0] pfo;
  int err_count = 0;
  int check_count = 0;
  int lat, base0, bl;
  always #50 clk = ~clk;
  always #350 slow = ~slow;
  csel_pin_timing i_csel_pin_timing (.CLK_SYS_I(clk), .RST_I(rst),
    .PIN_FUNC_WR_I(pf), .PIN_FUNC_WE_I(pf_we), .OPT_WE_I(owe),
    .OPT_BYTE_I(byt), .OPT_RW_I(rw), .OPT_SPACE_I(sp), .OPT_IPL_I(interrupt_level_match),
    .OPT_WAIT_I(wt), .OPT_MODE_I(md), .OPT_STROBE_SELECT_I(strobe_select), .OPT_AUTOVECTOR_REQUEST_I(av),
    .OPT_BASE_I(base), .OPT_MASK_I(mask), .PORTC_DATA_I(pc),
    .STRAP_LOW_I(strap), .ADDR_I(addr), .FC_I(fc), .RD_I(rd), .SIZE_I(siz),
    .IACK_I(iack), .INTERNAL_HIT_I(hit), .AS_I(as), .DS_I(as),
    .EXT_ACK_I(xack), .SLOW_CLK_I(slow), .EBU_GRANT_I(grant),
    .SEL_N_O(sel_n), .PIN_ALT_O(alt), .PIN_DISC_O(disc),
    .PIN_DISC_VAL_O(dval), .ACK_LO_O(lo), .ACK_HI_O(hi), .AUTOVECTOR_REQUEST_O(avo),
    .SLOW_PEND_O(pend), .CYCLE_END_O(ce), .PIN_FUNC_O(pfo));
  ext_periph i_ext_periph (.clk_i(clk), .sel_n_i(sel_n[3]), .en_i(xen),
    .dly_i(xdly), .ack_o(xack));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                     input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  // one strobe cycle; lat counts edges to cycle end, 0 if none came
  task automatic acc(input logic [23:0] a, input logic r);
    lat = 0;
    seen = 12'h000;
    got_lo = 1'b0;
    got_hi = 1'b0;
    got_av = 1'b0;
    @(posedge clk);
    #10;
    addr = a;
    rd = r;
    as = 1'b1;
    // thirty-nine edges outlast two slow clock cycles, as a bus monitor must
    for (int i = 1; i < 40 && lat == 0; i++) begin
      @(posedge clk);
      #1;
      seen = seen | ~sel_n;
      got_lo = got_lo | lo;
      got_hi = got_hi | hi;
      got_av = got_av | avo;
      if (ce === 1'b1) lat = i;
    end
    #9;
    as = 1'b0;
  endtask : acc
  // pin function of select 3, byte lanes of select 3 loaded too
  task automatic setpf(input logic [1:0] f);
    @(posedge clk);
    #10;
    pf[7:6] = f;
    pf_we = 1'b1;
    owe[3] = 1'b1;
    @(posedge clk);
    #10;
    pf_we = 1'b0;
    owe = 12'h000;
  endtask : setpf
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial begin
    base[51:39] = 13'h0100;
    repeat (12) @(posedge clk);
    #10;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(sel_n, 12'hfff, "selects idle");
    chk(alt | disc, 12'h000, "pins not select");
    chk({10'h0, pfo}, {10'h0, PA_CS16}, "boot function");
    // general selects other than 3 share the boot range but stay disabled
    acc(24'h000100, 1'b1);
    bl = lat;
    chk(seen, 12'h800, "boot only");
    chk({10'h0, got_hi, got_lo}, 12'h002, "boot ack lane");
    hit = 1'b1;
    acc(24'h000100, 1'b1);
    hit = 1'b0;
    chk({seen[11:1], got_hi}, 12'h000, "internal wins");
    $display("test reset and disable done");
    setpf(PA_CS8);
    wt[15:12] = WAIT_ZERO;
    acc(24'h080000, 1'b1);
    base0 = lat;
    chk(seen, 12'h008, "select 3 only");
    chk({10'h0, got_hi, got_lo}, 12'h001, "8-bit ack lane");
    chk(bl == base0 + 2, 1'b1, "boot wait count");
    foreach (wt[n]) begin
      if (n == 1 || n == 5 || n == 13) begin
        wt[15:12] = n[3:0];
        acc(24'h080000, 1'b0);
        chk(lat == base0 + n, 1'b1, "wait count");
      end
    end
    wt[15:12] = WAIT_FAST;
    acc(24'h080000, 1'b1);
    chk(lat == base0 - 1 && got_lo, 1'b1, "fast end");
    rw[7:6] = RW_READ;
    acc(24'h080000, 1'b0);
    chk(seen, 12'h000, "direction refused");
    rw[7:6] = 2'h3;
    $display("test wait states done");
    xen = 1'b1;
    xdly = 8'd20;
    wt[15:12] = WAIT_EXT;
    acc(24'h080000, 1'b1);
    // device acks its delay plus one edge after select, cycle ends next
    chk(lat == xdly + 3 && !got_lo, 1'b1, "external wait");
    xdly = 8'd2;
    wt[15:12] = 4'hd;
    // let the slow device drop its held acknowledge first
    repeat (2) @(posedge clk);
    acc(24'h080000, 1'b1);
    chk(lat == xdly + 3 && !got_lo, 1'b1, "abort in count");
    xen = 1'b0;
    $display("test external ack done");
    md[3] = 1'b1;
    acc(24'h080000, 1'b1);
    chk(seen, 12'h000, "no select before grant");
    chk({11'h0, pend}, 12'h001, "slow cycle pending");
    grant = 1'b1;
    acc(24'h080000, 1'b1);
    chk(seen, 12'h008, "select after grant");
    chk({10'h0, lat == 0, got_lo | got_hi | got_av}, 12'h002, "no ack");
    md[3] = 1'b0;
    grant = 1'b0;
    $display("test slow clock mode done");
    setpf(PA_DISCRETE);
    wt[15:12] = WAIT_ONE;
    repeat (3) @(posedge clk);
    #1;
    chk({disc[3], dval[3]}, {1'b1, pc[0]}, "discrete level");
    acc(24'h080000, 1'b1);
    chk(got_lo | got_hi, 1'b1, "match on discrete pin");
    chk(seen, 12'h000, "no select on discrete pin");
    chk(lat == base0 + 1, 1'b1, "discrete pin wait");
    $display("test discrete done");
    fc = FC_CPU;
    sp[7:6] = SP_CPU;
    interrupt_level_match[11:9] = 3'h3;
    av[3] = 1'b1;
    iack = 1'b1;
    acc(24'h080006, 1'b1);
    chk({10'h0, got_av, got_lo | got_hi}, 12'h002, "autovector");
    chk(lat == base0 + 1, 1'b1, "autovector wait");
    acc(24'h080004, 1'b1);
    chk({10'h0, lat == 0, got_av}, 12'h002, "level refused");
    iack = 1'b0;
    av = 12'h000;
    $display("test autovector done");
    strap = 12'h809;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #10;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(alt, 12'h009, "strapped pins alternate");
    chk(sel_n & ~disc, 12'hfff, "selects idle after reset");
    $display("test strap reset done");
    summarize();
  end
  // whole run is well under 100 us; twenty times that means a hang
  initial begin
    #2000000;
    err_count++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
